// File: verilog/host_control_sync_interrupt.sv
`timescale 1ns/1ps
`include "gcb_consts.svh"
// Contract
// R01: sixteen-bit two-way data bus, six address lines, memory-like port.
// R02: addresses 32..63 are global, 0..31 are paged.
// R03: writing global 33 sets page; paged accesses then use that page.
// R04: top address bit selects global space; page register at 0x21.
// R05: clock enable cleared holds internal receive clock low.
// R06: eleven output-disable bits float their pin groups.
// R07: functional reset holds datapath reset, control registers untouched.
// R08: host uses active-low read, write and chip enable strobes.
// R09: three-strobe mode and two-strobe mode with read held low.
// R10: drive data only with chip enable and read low, write high.
// R11: sync pins sampled on receive clock rising edge.
// R12: sync select codes pick pins, counter, one-shot, zero or one.
// R13: each synchronised function has its own independent sync select.
// R14: one-shot fires only on rising edge of its control bit.
// R15: 32-bit counter loads terminal count on sync, counts down.
// R16: terminal pulse lasts the eight-bit width field in cycles; a zero width gives one cycle here.
// R17: terminal count usable as sync source and on sync out pin.
// R18: output-disable bit zero floats interrupt and sync out pins.
// R19: interrupt active when any unmasked source flagged.
// R20: host reads status, then writes it to clear written sources.
// R21: sixteen sources: eight channel, four input meters, four overflows.
// R22: interrupt clear control holds flags clear and pin low.
module host_control_sync_interrupt (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // host port
  input  wire logic [5:0]  i_addr,
  input  wire logic [15:0] i_data,
  output logic      [15:0] o_data,
  output logic             o_data_oe_b,
  input  wire logic        i_rd_b,
  input  wire logic        i_wr_b,
  input  wire logic        i_ce_b,
  // paged register access
  output logic      [15:0] o_page,
  output logic      [4:0]  o_paged_addr,
  output logic      [15:0] o_paged_wdata,
  output logic             o_paged_wr,
  input  wire logic [15:0] i_paged_rdata,
  // clock, reset and pin control
  input  wire logic        i_rxclk_gate,
  output logic             o_rxclk_int,
  output logic      [10:0] o_pin_group_oe_b,
  output logic             o_datapath_rst,
  // sync
  input  wire logic [3:0]  i_sync_pin,
  output logic      [7:0]  o_sync,
  output logic             o_sync_out,
  output logic             o_sync_out_oe_b,
  // interrupt sources
  input  wire logic [7:0]  i_channel_meter_irq,
  input  wire logic [3:0]  i_input_meter_irq,
  input  wire logic [3:0]  i_overflow_irq,
  output logic             o_irq,
  output logic             o_irq_oe_b
);
  // ****************************************************
  // host port decode
  // ****************************************************
  logic [15:0] page_select;
  logic [15:0] next_page_select;
  logic [10:0] tristate_ctrl;
  logic [10:0] next_tristate_ctrl;
  logic [3:0]  ctrl;
  logic [3:0]  next_ctrl;
  logic [23:0] sync_select;
  logic [23:0] next_sync_select;
  logic [31:0] terminal_count;
  logic [31:0] next_terminal_count;
  logic [7:0]  tc_width;
  logic [7:0]  next_tc_width;
  logic [15:0] irq_mask;
  logic [15:0] next_irq_mask;
  logic [15:0] irq_flag;
  logic [15:0] next_irq_flag;
  logic        wr_q;
  logic        wr_edge;
  logic        is_global;
  logic [15:0] rd_word;
  logic [15:0] irq_src;
  logic        tc;

  // write taken on the rising edge of the strobe pair so data has settled
  assign wr_edge   = wr_q && (i_ce_b || i_wr_b); // R08 R09
  assign is_global = i_addr[5]; // R02 R04
  assign irq_src   = {i_overflow_irq, i_input_meter_irq,
                      i_channel_meter_irq}; // R21

  logic [5:0] addr_q;
  logic [15:0] data_q;
  logic       next_wr_q;

  always_comb begin
    next_wr_q = !i_ce_b && !i_wr_b;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_q   <= 1'b0;
      addr_q <= 6'h00;
      data_q <= 16'h0000;
    end else begin
      wr_q <= next_wr_q;
      if (next_wr_q) begin
        addr_q <= i_addr;
        data_q <= i_data;
      end
    end
  end

  // ****************************************************
  // global registers
  // ****************************************************
  // control registers survive the functional reset
  always_comb begin
    next_page_select    = page_select;
    next_tristate_ctrl  = tristate_ctrl;
    next_ctrl           = ctrl;
    next_sync_select    = sync_select;
    next_terminal_count = terminal_count;
    next_tc_width       = tc_width;
    next_irq_mask       = irq_mask;
    if (wr_edge && addr_q[5]) begin
      case (addr_q)
        `GCB_A_PAGE:      next_page_select = data_q; // R03 R04
        `GCB_A_TRISTATE:  next_tristate_ctrl = data_q[10:0];
        `GCB_A_CTRL:      next_ctrl = data_q[3:0];
        `GCB_A_SSEL0:     next_sync_select[14:0] = data_q[14:0]; // R13
        `GCB_A_SSEL1:     next_sync_select[23:15] = data_q[8:0]; // R13
        `GCB_A_CNT_LO:    next_terminal_count[15:0] = data_q;
        `GCB_A_CNT_HI:    next_terminal_count[31:16] = data_q;
        `GCB_A_CNT_WIDTH: next_tc_width = data_q[7:0];
        `GCB_A_IRQ_MASK:  next_irq_mask = data_q;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      page_select    <= `GCB_RST_PAGE;
      tristate_ctrl  <= `GCB_RST_TRISTATE;
      ctrl           <= `GCB_RST_CTRL;
      sync_select    <= {`GCB_NUM_SYNC{`GCB_RST_SSEL}};
      terminal_count <= 32'h0;
      tc_width       <= 8'h0;
      irq_mask       <= `GCB_RST_IRQ_MASK;
    end else begin
      page_select    <= next_page_select;
      tristate_ctrl  <= next_tristate_ctrl;
      ctrl           <= next_ctrl;
      sync_select    <= next_sync_select;
      terminal_count <= next_terminal_count;
      tc_width       <= next_tc_width;
      irq_mask       <= next_irq_mask;
    end
  end

  // paged space passes through with the current page
  assign o_page        = page_select; // R03
  assign o_paged_addr  = addr_q[4:0];
  assign o_paged_wdata = data_q;
  assign o_paged_wr    = wr_edge && !addr_q[5]; // R02

  // ****************************************************
  // read path
  // ****************************************************
  always_comb begin
    rd_word = 16'h0000;
    if (!is_global) begin
      rd_word = i_paged_rdata; // R02
    end else begin
      case (i_addr)
        `GCB_A_STATUS:    rd_word = {11'h000, tc, ctrl};
        `GCB_A_PAGE:      rd_word = page_select;
        `GCB_A_TRISTATE:  rd_word = {5'h00, tristate_ctrl};
        `GCB_A_CTRL:      rd_word = {12'h000, ctrl};
        `GCB_A_SSEL0:     rd_word = {1'b0, sync_select[14:0]};
        `GCB_A_SSEL1:     rd_word = {7'h00, sync_select[23:15]};
        `GCB_A_CNT_LO:    rd_word = terminal_count[15:0];
        `GCB_A_CNT_HI:    rd_word = terminal_count[31:16];
        `GCB_A_CNT_WIDTH: rd_word = {8'h00, tc_width};
        `GCB_A_IRQ_FLAG:  rd_word = irq_flag; // R20
        `GCB_A_IRQ_MASK:  rd_word = irq_mask;
        default:          rd_word = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_data <= 16'h0000;
    end else begin
      o_data <= rd_word; // R01
    end
  end

  // two-strobe mode leaves read low, so write high gates the drive
  assign o_data_oe_b = !(!i_ce_b && !i_rd_b && i_wr_b); // R10 R09

  // ****************************************************
  // clock gate, resets and pin disables
  // ****************************************************
  // gating cell stand-in: enable is a register, so no glitch from logic
  assign o_rxclk_int      = i_rxclk_gate && ctrl[`GCB_CTRL_RXCLK_ENA]; // R05
  assign o_datapath_rst   = ctrl[`GCB_CTRL_ARST_FUNC]; // R07
  assign o_pin_group_oe_b = tristate_ctrl; // R06
  assign o_irq_oe_b       = tristate_ctrl[0]; // R18
  assign o_sync_out_oe_b  = tristate_ctrl[0]; // R18

  // ****************************************************
  // sync sources
  // ****************************************************
  logic [3:0] sync_pin_q;
  logic       oneshot_q;
  logic       oneshot;
  logic       next_oneshot;
  logic [7:0] next_sync;

  always_comb begin
    next_oneshot = ctrl[`GCB_CTRL_ONESHOT] && !oneshot_q; // R14
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_pin_q <= 4'h0;
      oneshot_q  <= 1'b0;
      oneshot    <= 1'b0;
    end else begin
      sync_pin_q <= i_sync_pin; // R11
      oneshot_q  <= ctrl[`GCB_CTRL_ONESHOT];
      oneshot    <= next_oneshot;
    end
  end

  // slot 0 loads the counter, slot 1 drives the sync out pin
  genvar g;
  generate
    for (g = 0; g < `GCB_NUM_SYNC; g = g + 1) begin : g_sel
      logic [2:0] code;
      assign code = sync_select[3*g+2:3*g];
      always_comb begin
        case (code)
          `GCB_SS_COUNTER: next_sync[g] = tc; // R12 R17
          `GCB_SS_ONESHOT: next_sync[g] = oneshot; // R12
          `GCB_SS_ZERO:    next_sync[g] = 1'b0;
          `GCB_SS_ONE:     next_sync[g] = 1'b1;
          default:         next_sync[g] = sync_pin_q[code[1:0]]; // R12
        endcase
      end
    end
  endgenerate

  assign o_sync     = next_sync; // R13
  assign o_sync_out = next_sync[1]; // R17

  sync_counter u_counter (
    .i_clk          (i_clk),
    .i_rst_b        (i_rst_b),
    .i_datapath_rst (ctrl[`GCB_CTRL_ARST_FUNC]),
    .i_load         (next_sync[0]),
    .i_terminal     (terminal_count),
    .i_width        (tc_width),
    .o_tc           (tc)
  );

  // ****************************************************
  // interrupts
  // ****************************************************
  always_comb begin
    next_irq_flag = irq_flag;
    if (wr_edge && addr_q == `GCB_A_IRQ_FLAG) begin
      next_irq_flag = irq_flag & ~data_q; // R20
    end
    // a new event in the clearing cycle survives
    next_irq_flag = next_irq_flag | irq_src;
    if (ctrl[`GCB_CTRL_INTR_CLR]) begin
      next_irq_flag = 16'h0000; // R22
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_flag <= 16'h0000;
      o_irq    <= 1'b0;
    end else begin
      irq_flag <= next_irq_flag;
      o_irq    <= |(next_irq_flag & ~next_irq_mask) &&
                  !next_ctrl[`GCB_CTRL_INTR_CLR]; // R19 R22
    end
  end
endmodule : host_control_sync_interrupt

// File: common/gcb_consts.svh
`ifndef GCB_CONSTS_SVH
`define GCB_CONSTS_SVH
// global address map, six-bit port address
`define GCB_A_STATUS     6'h20
`define GCB_A_PAGE       6'h21
`define GCB_A_TRISTATE   6'h22
`define GCB_A_CTRL       6'h23
`define GCB_A_SSEL0      6'h24
`define GCB_A_SSEL1      6'h25
`define GCB_A_CNT_LO     6'h26
`define GCB_A_CNT_HI     6'h27
`define GCB_A_CNT_WIDTH  6'h28
`define GCB_A_IRQ_FLAG   6'h29
`define GCB_A_IRQ_MASK   6'h2a
// control register fields
`define GCB_CTRL_RXCLK_ENA  0
`define GCB_CTRL_ARST_FUNC  1
`define GCB_CTRL_ONESHOT    2
`define GCB_CTRL_INTR_CLR   3
// reset values
`define GCB_RST_PAGE      16'h0000
`define GCB_RST_TRISTATE  11'h7ff
`define GCB_RST_CTRL      4'h3
`define GCB_RST_SSEL      3'h6
`define GCB_RST_IRQ_MASK  16'hffff
// sync select codes
`define GCB_SS_COUNTER    3'h4
`define GCB_SS_ONESHOT    3'h5
`define GCB_SS_ZERO       3'h6
`define GCB_SS_ONE        3'h7
// layout
`define GCB_NUM_SYNC      8
`define GCB_NUM_IRQ       16
`endif

// File: common/gcb_pkg.sv
package gcb_pkg;
  typedef logic [2:0]  sync_sel_t;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {
    cnt_idle,
    cnt_down,
    cnt_pulse
  } cnt_state_e;
endpackage : gcb_pkg

// File: verilog/sync_counter.sv
`timescale 1ns/1ps
module sync_counter (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // control
  input  wire logic        i_datapath_rst,
  input  wire logic        i_load,
  input  wire logic [31:0] i_terminal,
  input  wire logic [7:0]  i_width,
  // terminal count
  output logic             o_tc
);
  gcb_pkg::cnt_state_e state;
  gcb_pkg::cnt_state_e next_state;
  logic [31:0]         count;
  logic [31:0]         next_count;
  logic [7:0]          pulse;
  logic [7:0]          next_pulse;
  logic                next_tc;

  always_comb begin
    next_state = state;
    next_count = count;
    next_pulse = pulse;
    next_tc    = 1'b0;
    case (state)
      gcb_pkg::cnt_idle: begin
      end
      gcb_pkg::cnt_down: begin
        if (count == 32'h0) begin
          // zero width still gives one cycle so the edge is seen
          next_tc    = 1'b1;
          next_pulse = (i_width == 8'h0) ? 8'h0 : i_width - 8'h1; // R16
          next_state = gcb_pkg::cnt_pulse;
        end else begin
          next_count = count - 32'h1; // R15
        end
      end
      gcb_pkg::cnt_pulse: begin
        if (pulse != 8'h0) begin
          next_tc    = 1'b1; // R16
          next_pulse = pulse - 8'h1;
        end else begin
          next_state = gcb_pkg::cnt_idle;
        end
      end
      default: next_state = gcb_pkg::cnt_idle;
    endcase
    // a sync reloads from any state
    if (i_load) begin
      next_count = i_terminal; // R15
      next_state = gcb_pkg::cnt_down;
      next_tc    = 1'b0;
    end
    if (i_datapath_rst) begin
      next_state = gcb_pkg::cnt_idle;
      next_count = 32'h0;
      next_pulse = 8'h0;
      next_tc    = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= gcb_pkg::cnt_idle;
      count <= 32'h0;
      pulse <= 8'h0;
      o_tc  <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      pulse <= next_pulse;
      o_tc  <= next_tc;
    end
  end
endmodule : sync_counter

// File: sim/gcb_sva.sv
`timescale 1ns/1ps
module gcb_sva (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  // host port
  input wire logic [5:0]  i_addr,
  input wire logic [15:0] i_data,
  input wire logic        i_rd_b,
  input wire logic        i_wr_b,
  input wire logic        i_ce_b,
  input wire logic        o_data_oe_b,
  input wire logic [15:0] o_page,
  input wire logic [4:0]  o_paged_addr,
  input wire logic [15:0] o_paged_wdata,
  input wire logic        o_paged_wr,
  // pins
  input wire logic        i_rxclk_gate,
  input wire logic        o_rxclk_int,
  input wire logic [10:0] o_pin_group_oe_b,
  input wire logic        o_datapath_rst,
  input wire logic [7:0]  o_sync,
  input wire logic        o_sync_out,
  input wire logic        o_sync_out_oe_b,
  // interrupt
  input wire logic [7:0]  i_channel_meter_irq,
  input wire logic [3:0]  i_input_meter_irq,
  input wire logic [3:0]  i_overflow_irq,
  input wire logic        o_irq,
  input wire logic        o_irq_oe_b
);
  logic any_src;
  assign any_src = |{i_channel_meter_irq, i_input_meter_irq, i_overflow_irq};
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // ****
  // properties
  // ****
  // a write is taken on the first edge that sees a strobe released
  sequence s_wr; !i_ce_b && !i_wr_b ##1 (i_ce_b || i_wr_b); endsequence
  property p_drive; o_data_oe_b == !(!i_ce_b && !i_rd_b && i_wr_b); endproperty
  a_drive: assert property (p_drive) else $error("bad bus drive");
  property p_page; i_addr == 6'h21 ##0 s_wr |=> o_page == $past(i_data, 2);
  endproperty
  a_page: assert property (p_page) else $error("page not set");
  // the strobe pulse stands in the cycle the release is seen
  property p_paged; !i_addr[5] ##0 s_wr |-> o_paged_wr &&
    $past(i_addr) == {1'b0, o_paged_addr} &&
    o_paged_wdata == $past(i_data); endproperty
  a_paged: assert property (p_paged) else $error("paged write lost");
  property p_pulse; o_paged_wr |=> !o_paged_wr; endproperty
  a_pulse: assert property (p_pulse) else $error("paged pulse long");
  property p_tri0; o_irq_oe_b == o_pin_group_oe_b[0] &&
    o_sync_out_oe_b == o_pin_group_oe_b[0]; endproperty
  a_tri0: assert property (p_tri0) else $error("bit0 float wrong");
  property p_rxclk; o_rxclk_int |-> i_rxclk_gate; endproperty
  a_rxclk: assert property (p_rxclk) else $error("clock leak");
  property p_out; o_sync_out == o_sync[1]; endproperty
  a_out: assert property (p_out) else $error("sync out slot");
  // a mask write can also raise the pin over a standing flag
  property p_cause; $rose(o_irq) |-> $past(any_src) ||
    $past(!i_ce_b && !i_wr_b, 2); endproperty
  a_cause: assert property (p_cause) else $error("irq no cause");
  property p_arst; $changed(o_datapath_rst) |-> $past(i_addr, 2) == 6'h23;
  endproperty
  a_arst: assert property (p_arst) else $error("reset moved");
  c_paged: cover property (o_paged_wr);
  c_irq: cover property ($rose(o_irq));
  c_sync: cover property (o_sync_out);
endmodule : gcb_sva
bind host_control_sync_interrupt gcb_sva u_sva (.*);

// File: sim/host_port_model.sv
`timescale 1ns/1ps
module host_port_model (
  // clock
  input  wire logic        i_clk,
  // device side
  input  wire logic [15:0] i_dev_data,
  input  wire logic        i_dev_oe_b,
  // host bus
  output logic      [5:0]  o_addr,
  output wire logic [15:0] o_data,
  output logic             o_rd_b,
  output logic             o_wr_b,
  output logic             o_ce_b
);
  logic        two_pin;
  logic        drv;
  logic [15:0] d;
  // undriven wire shows the inverse, never a stale match
  assign o_data = !i_dev_oe_b ? i_dev_data : drv ? d : ~d;
  initial begin
    {two_pin, drv, d, o_addr} = '0;
    {o_rd_b, o_wr_b, o_ce_b} = 3'b111;
  end
  task automatic idle();
    {o_ce_b, o_wr_b, drv} = 3'b110;
    o_rd_b = !two_pin;
    @(negedge i_clk);
  endtask : idle
  task automatic write(logic [5:0] a, logic [15:0] v);
    {o_addr, d, drv} = {a, v, 1'b1};
    {o_ce_b, o_wr_b, o_rd_b} = {2'b00, !two_pin};
    @(negedge i_clk);
    {o_ce_b, o_wr_b} = 2'b11;
    repeat (2) @(negedge i_clk);
    drv = 1'b0;
  endtask : write
  task automatic read(logic [5:0] a);
    o_addr = a;
    {o_ce_b, o_wr_b, o_rd_b} = 3'b010;
    @(negedge i_clk);
  endtask : read
endmodule : host_port_model

// File: sim/host_control_sync_interrupt_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  mismatches++; $display("unexpected at %0t: %h not %h", $time, a, e); \
  end end
module host_control_sync_interrupt_tb;
  logic        i_clk, i_rst_b, i_rxclk_gate;
  logic [15:0] i_paged_rdata, obs, pg, p;
  logic [3:0]  i_sync_pin, i_input_meter_irq, i_overflow_irq;
  logic [7:0]  i_channel_meter_irq;
  wire  [5:0]  i_addr;
  wire  [15:0] i_data, o_data, o_page, o_paged_wdata;
  wire  [4:0]  o_paged_addr;
  wire  [10:0] o_pin_group_oe_b;
  wire  [7:0]  o_sync;
  wire         i_rd_b, i_wr_b, i_ce_b, o_data_oe_b, o_paged_wr, o_rxclk_int;
  wire         o_datapath_rst, o_sync_out, o_sync_out_oe_b, o_irq, o_irq_oe_b;
  int          mismatches, total_checks, pulses;
  logic [17:0] exp_q[$];
  logic [17:0] e;
  event        chk_ev;
  logic [5:0]  ra[6] = '{6'h21, 6'h22, 6'h23, 6'h2a, 6'h29, 6'h3f};
  logic [15:0] rv[6] = '{16'h0, 16'h7ff, 16'h3, 16'hffff, 16'h0, 16'h0};
  host_control_sync_interrupt uut (.*);
  host_port_model host (.i_clk(i_clk), .i_dev_data(o_data),
    .i_dev_oe_b(o_data_oe_b), .o_addr(i_addr), .o_data(i_data),
    .o_rd_b(i_rd_b), .o_wr_b(i_wr_b), .o_ce_b(i_ce_b));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (o_sync[1] === 1'b1) pulses++;
  // ****
  // result monitor
  // ****
  always begin
    @(chk_ev);
    e = exp_q.pop_front();
    case (e[17:16])
      2'd0: obs = o_data;
      2'd1: obs = o_page;
      2'd2: obs = {o_pin_group_oe_b, o_datapath_rst, o_rxclk_int, o_irq,
                   o_sync[1:0]};
      default: obs = pulses[15:0];
    endcase
    `CHK(obs, e[15:0])
  end
  task automatic chk(logic [1:0] k, logic [15:0] v);
    exp_q.push_back({k, v});
    -> chk_ev;
  endtask : chk
  task automatic rd(logic [5:0] a, logic [15:0] v);
    host.read(a);
    chk(2'd0, v);
    host.idle();
  endtask : rd
  task automatic w(int n);
    repeat (n) @(negedge i_clk);
  endtask : w
  task automatic src(logic [15:0] v);
    {i_overflow_irq, i_input_meter_irq, i_channel_meter_irq} = v;
    w(1);
    {i_overflow_irq, i_input_meter_irq, i_channel_meter_irq} = '0;
    w(1);
  endtask : src
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end
  // ****
  // scenarios
  // ****
  initial begin
    {i_rst_b, i_paged_rdata, i_sync_pin, pulses} = '0;
    {i_overflow_irq, i_input_meter_irq, i_channel_meter_irq} = '0;
    {i_rxclk_gate, mismatches, total_checks} = {1'b1, 64'h0};
    void'($urandom(32'ha3df7a5a));
    w(6);
    i_rst_b = 1'b1;
    chk(2'd2, {11'h7ff, 2'b11, 3'b000});
    foreach (ra[i]) rd(ra[i], rv[i]);
    pg = 16'($urandom);
    host.write(6'h21, pg);
    chk(2'd1, pg);
    p = 16'($urandom);
    i_paged_rdata = ~p;
    host.write(6'h05, p);
    rd(6'h05, ~p);
    host.write(6'h3f, 16'h5a5a);
    host.write(6'h20, 16'h5a5a);
    rd(6'h3f, 16'h0000);
    host.two_pin = 1'b1;
    host.write(6'h22, 16'h0001);
    rd(6'h22, 16'h0001);
    host.two_pin = 1'b0;
    chk(2'd2, {11'h001, 2'b11, 3'b000});
    host.write(6'h23, 16'h0000);
    chk(2'd2, {11'h001, 2'b00, 3'b000});
    rd(6'h21, pg);
    host.write(6'h23, 16'h0001);
    i_sync_pin = 4'($urandom);
    for (int c = 0; c < 8; c++) begin
      host.write(6'h24, {10'h0, 3'(c), 3'h6});
      chk(2'd2, {11'h001, 3'b010, (c < 4) ? i_sync_pin[c[1:0]] : 1'(c == 7),
                 1'b0});
    end
    host.write(6'h24, {10'h0, 3'h5, 3'h6});
    pulses = 0;
    host.write(6'h23, 16'h0005);
    w(8);
    chk(2'd3, 16'd1);
    host.write(6'h23, 16'h0005);
    w(8);
    chk(2'd3, 16'd1);
    host.write(6'h26, 16'h0003);
    host.write(6'h27, 16'h0000);
    host.write(6'h28, 16'h0003);
    host.write(6'h24, {10'h0, 3'h4, 3'h5});
    host.write(6'h23, 16'h0001);
    pulses = 0;
    host.write(6'h23, 16'h0005);
    w(30);
    chk(2'd3, 16'd3);
    host.write(6'h2a, 16'hfffe);
    src(16'h0001);
    chk(2'd2, {11'h001, 3'b011, 2'b00});
    rd(6'h29, 16'h0001);
    src(16'h0002);
    rd(6'h29, 16'h0003);
    host.write(6'h29, 16'h0001);
    chk(2'd2, {11'h001, 3'b010, 2'b00});
    rd(6'h29, 16'h0002);
    host.write(6'h2a, 16'h0000);
    host.write(6'h29, 16'hffff);
    p = 16'($urandom) | 16'h0001;
    src(p);
    rd(6'h29, p);
    host.write(6'h29, p);
    chk(2'd2, {11'h001, 3'b010, 2'b00});
    host.write(6'h23, 16'h000d);
    src(16'hffff);
    rd(6'h29, 16'h0000);
    chk(2'd2, {11'h001, 3'b010, 2'b00});
    finish_test();
  end
endmodule : host_control_sync_interrupt_tb
